// file: mmc_pkg.sv
`default_nettype none
package mmc_pkg;
   // Register offsets
   localparam logic [15:0] MMC_GENCFG_OFS = 16'he618;
   localparam logic [15:0] MMC_MEASUREMENT_MODE_OFS = 16'he700;
   localparam logic [15:0] MMC_ACCUMULATION_MODE_OFS = 16'he701;
   localparam logic [15:0] MMC_PKSTAT_OFS = 16'he7f0;
   // Reset values
   localparam logic [15:0] MMC_GENCFG_RST = 16'h0000;
   localparam logic [7:0] MMC_MEASUREMENT_MODE_RST = 8'h1c;
   localparam logic [7:0] MMC_ACCUMULATION_MODE_RST = 8'h00;
   // measurement_mode fields
   localparam int MMC_LINE_PERIOD_PHASE_SELECT_LSB = 0;
   localparam int MMC_PEAK_PHASE_SELECT_LSB = 2;
   localparam int MMC_MEASUREMENT_MODE_RSV_LSB = 5;
   localparam logic [7:0] MMC_MEASUREMENT_MODE_WMASK = 8'h1f;
   // accumulation_mode fields
   localparam int MMC_ACTIVE_ENERGY_ACCUM_MODE_LSB = 0;
   localparam logic [7:0] MMC_ACCUMULATION_MODE_WMASK = 8'hff;
   // Period source codes
   localparam logic [1:0] MMC_PER_A = 2'h0;
   localparam logic [1:0] MMC_PER_B = 2'h1;
   localparam logic [1:0] MMC_PER_C = 2'h2;
   // Active accumulation codes
   localparam logic [1:0] MMC_ACC_ABS = 2'h3;
   // Datapath widths
   localparam int MMC_PWR_W = 24;
   localparam int MMC_PKCNT_W = 10;
   typedef enum logic [1:0] {
      MMC_PK_IDLE = 2'b01,
      MMC_PK_RUN = 2'b10
   } mmc_pk_state_t;
endpackage
`default_nettype wire

// file: mmc_mode_regs.sv
// Summary of operation
// - Period source code 00/01/10 picks A/B/C
// - Period code 11 acts as Phase A
// - Bits 2,3,4 enable peak on A,B,C
// - Any peak phase combination runs together
// - Mode bits 7:5 reserved, zero, unused
// - Accumulation code 00 gives signed power
// - Codes 01 and 10 act as signed
// - Code 11 gives absolute power
`timescale 1ns/100ps
`default_nettype none
module mmc_mode_regs
   import mmc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic zc_a,
   input wire logic zc_b,
   input wire logic zc_c,
   input wire logic [7:0] peak_window_cycles,
   input wire logic peak_start,
   output logic period_zc,
   output logic [1:0] period_phase,
   output logic [2:0] peak_phase_en,
   output logic peak_window_done,
   output logic peak_busy,
   input wire logic [MMC_PWR_W-1:0] active_power,
   input wire logic active_power_vld,
   output logic [MMC_PWR_W:0] accum_power,
   output logic accum_power_vld,
   output logic [15:0] general_configuration
);

   logic [15:0] gencfg_r;
   logic [7:0] measurement_mode_r;
   logic [7:0] accumulation_mode_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [1:0] line_period_phase_select;
   logic [2:0] peak_phase_select;
   logic [1:0] active_energy_accum_mode;
   logic [1:0] per_eff;
   logic [1:0] zc_inc;
   logic [MMC_PKCNT_W-1:0] pk_cnt_r;
   logic [MMC_PKCNT_W-1:0] pk_cnt_nxt;
   logic [MMC_PKCNT_W-1:0] pk_target_r;
   logic pk_done_r;
   logic per_zc_r;
   logic [1:0] per_phase_r;
   logic [MMC_PWR_W:0] acc_r;
   logic acc_vld_r;
   logic [MMC_PWR_W:0] pwr_ext;
   mmc_pk_state_t pk_state_r;

   // Register writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gencfg_r <= MMC_GENCFG_RST;
      end else if (reg_wr && reg_addr == MMC_GENCFG_OFS) begin
         gencfg_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         measurement_mode_r <= MMC_MEASUREMENT_MODE_RST;
      end else if (reg_wr && reg_addr == MMC_MEASUREMENT_MODE_OFS) begin
         measurement_mode_r <= reg_wdata[7:0] & MMC_MEASUREMENT_MODE_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         accumulation_mode_r <= MMC_ACCUMULATION_MODE_RST;
      end else if (reg_wr && reg_addr == MMC_ACCUMULATION_MODE_OFS) begin
         accumulation_mode_r <= reg_wdata[7:0] & MMC_ACCUMULATION_MODE_WMASK;
      end
   end

   // Register write checks
   a_gencfg_write: assert property (@(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr == MMC_GENCFG_OFS |=> general_configuration == $past(reg_wdata)
      ) else $error("general_configuration not updated");
   a_gencfg_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(reg_wr && reg_addr == MMC_GENCFG_OFS) |=> $stable(general_configuration)
      ) else $error("general_configuration changed without write");
   a_accumulation_mode_write: assert property (@(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr == MMC_ACCUMULATION_MODE_OFS |=> accumulation_mode_r == $past(reg_wdata[7:0])
      ) else $error("accumulation_mode not updated");
   a_measurement_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(reg_wr && reg_addr == MMC_MEASUREMENT_MODE_OFS) |=> $stable(measurement_mode_r)
      ) else $error("measurement_mode changed without write");
   a_accumulation_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(reg_wr && reg_addr == MMC_ACCUMULATION_MODE_OFS) |=> $stable(accumulation_mode_r)
      ) else $error("accumulation_mode changed without write");

   // Field views
   assign line_period_phase_select = measurement_mode_r[MMC_LINE_PERIOD_PHASE_SELECT_LSB +: 2];
   assign peak_phase_select = measurement_mode_r[MMC_PEAK_PHASE_SELECT_LSB +: 3];
   assign active_energy_accum_mode = accumulation_mode_r[MMC_ACTIVE_ENERGY_ACCUM_MODE_LSB +: 2];
   assign general_configuration = gencfg_r;

   // Read data, one cycle after the strobe
   always_comb begin
      rdata_nxt = 16'h0000;
      case (reg_addr)
         MMC_GENCFG_OFS: rdata_nxt = gencfg_r;
         MMC_MEASUREMENT_MODE_OFS: rdata_nxt = {8'h00, measurement_mode_r};
         MMC_ACCUMULATION_MODE_OFS: rdata_nxt = {8'h00, accumulation_mode_r};
         MMC_PKSTAT_OFS: rdata_nxt = {peak_busy, 5'h00, pk_cnt_r};
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   assign reg_rdata = rdata_r;

   // Read data checks
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not cleared");
   a_measurement_mode_readback: assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == MMC_MEASUREMENT_MODE_OFS |=> reg_rdata == {8'h00, $past(measurement_mode_r)}
      ) else $error("measurement_mode readback mismatch");
   a_pkstat_read: assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == MMC_PKSTAT_OFS
      |=> reg_rdata == {$past(peak_busy), 5'h00, $past(pk_cnt_r)}) else $error("status read");

   // Line period source select
   always_comb begin
      case (line_period_phase_select)
         MMC_PER_B: per_eff = MMC_PER_B;
         MMC_PER_C: per_eff = MMC_PER_C;
         default: per_eff = MMC_PER_A;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         per_zc_r <= 1'b0;
         per_phase_r <= MMC_PER_A;
      end else begin
         per_phase_r <= per_eff;
         case (per_eff)
            MMC_PER_B: per_zc_r <= zc_b;
            MMC_PER_C: per_zc_r <= zc_c;
            default: per_zc_r <= zc_a;
         endcase
      end
   end

   assign period_zc = per_zc_r;
   assign period_phase = per_phase_r;

   // Period source checks
   a_per_phase_a: assert property (@(posedge clk) disable iff (!rstn)
      measurement_mode_r[1:0] == MMC_PER_A |=> period_zc == $past(zc_a) && period_phase == MMC_PER_A
      ) else $error("phase A period");
   a_per_phase_b: assert property (@(posedge clk) disable iff (!rstn)
      measurement_mode_r[1:0] == MMC_PER_B |=> period_zc == $past(zc_b) && period_phase == MMC_PER_B
      ) else $error("phase B period");

   // Peak phase enables and window count
   assign peak_phase_en = peak_phase_select;
   assign zc_inc = 2'({1'b0, zc_a & peak_phase_select[0]})
      + 2'({1'b0, zc_b & peak_phase_select[1]})
      + 2'({1'b0, zc_c & peak_phase_select[2]});
   assign pk_cnt_nxt = pk_cnt_r + MMC_PKCNT_W'(zc_inc);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pk_state_r <= MMC_PK_IDLE;
         pk_cnt_r <= '0;
         pk_target_r <= '0;
         pk_done_r <= 1'b0;
      end else begin
         pk_done_r <= 1'b0;
         case (pk_state_r)
            MMC_PK_IDLE: begin
               if (peak_start && peak_window_cycles != 8'h00) begin
                  pk_cnt_r <= '0;
                  pk_target_r <= MMC_PKCNT_W'(peak_window_cycles);
                  pk_state_r <= MMC_PK_RUN;
               end
            end
            MMC_PK_RUN: begin
               if (pk_cnt_nxt >= pk_target_r) begin
                  pk_cnt_r <= '0;
                  pk_done_r <= 1'b1;
                  pk_state_r <= MMC_PK_IDLE;
               end else begin
                  pk_cnt_r <= pk_cnt_nxt;
               end
            end
            default: pk_state_r <= MMC_PK_IDLE;
         endcase
      end
   end

   assign peak_window_done = pk_done_r;
   assign peak_busy = (pk_state_r == MMC_PK_RUN);

   // Peak window checks
   a_pk_start: assert property (@(posedge clk) disable iff (!rstn)
      !peak_busy && peak_start && peak_window_cycles != 8'h00
      |=> peak_busy && pk_cnt_r == 10'h000) else $error("peak window not started");
   a_pk_no_start: assert property (@(posedge clk) disable iff (!rstn)
      !peak_busy && !(peak_start && peak_window_cycles != 8'h00) |=> !peak_busy
      ) else $error("peak window started on its own");
   a_pk_hold: assert property (@(posedge clk) disable iff (!rstn)
      peak_busy && !zc_a && !zc_b && !zc_c |=> peak_busy && pk_cnt_r == $past(pk_cnt_r)
      ) else $error("peak count moved without crossing");
   a_pk_reach: assert property (@(posedge clk) disable iff (!rstn)
      peak_busy && zc_a && zc_b && zc_c && measurement_mode_r[4:2] == 3'h7
      && pk_cnt_r + 10'h003 >= pk_target_r
      |=> peak_window_done && !peak_busy && pk_cnt_r == 10'h000) else $error("window end");
   a_pk_done_idle: assert property (@(posedge clk) disable iff (!rstn)
      peak_window_done |-> !peak_busy) else $error("done while busy");

   // Active power accumulation term
   assign pwr_ext = {active_power[MMC_PWR_W-1], active_power};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_r <= '0;
         acc_vld_r <= 1'b0;
      end else begin
         acc_vld_r <= active_power_vld;
         if (active_power_vld) begin
            if (active_energy_accum_mode == MMC_ACC_ABS && pwr_ext[MMC_PWR_W]) begin
               acc_r <= (MMC_PWR_W+1)'(-pwr_ext);
            end else begin
               acc_r <= pwr_ext;
            end
         end
      end
   end

   assign accum_power = acc_r;
   assign accum_power_vld = acc_vld_r;

   // Accumulation checks
   a_acc_abs_value: assert property (@(posedge clk) disable iff (!rstn)
      active_power_vld && accumulation_mode_r[1:0] == MMC_ACC_ABS |=> accum_power[MMC_PWR_W-1:0]
      == ($past(active_power[MMC_PWR_W-1]) ? MMC_PWR_W'(-$past(active_power))
      : $past(active_power))) else $error("absolute accumulation value");
   a_acc_vld: assert property (@(posedge clk) disable iff (!rstn)
      active_power_vld |=> accum_power_vld) else $error("accumulation valid missing");
   a_acc_hold: assert property (@(posedge clk) disable iff (!rstn)
      !active_power_vld |=> !accum_power_vld && $stable(accum_power)
      ) else $error("accumulation term not held");

   // Checks
   a_measurement_mode_writeback: assert property (@(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr == MMC_MEASUREMENT_MODE_OFS
      |=> measurement_mode_r == ($past(reg_wdata[7:0]) & MMC_MEASUREMENT_MODE_WMASK)
      ) else $error("measurement_mode not updated");
   a_rsv_zero: assert property (@(posedge clk) disable iff (!rstn)
      measurement_mode_r[7:5] == 3'h0) else $error("reserved mode bits nonzero");
   a_readback: assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == MMC_ACCUMULATION_MODE_OFS && !reg_wr
      |=> reg_rdata == {8'h00, $past(accumulation_mode_r)}) else $error("readback mismatch");
   a_per_reserved: assert property (@(posedge clk) disable iff (!rstn)
      measurement_mode_r[1:0] == 2'h3 |=> period_zc == $past(zc_a) && period_phase == 2'h0
      ) else $error("reserved period code not phase A");
   a_per_phase_c: assert property (@(posedge clk) disable iff (!rstn)
      measurement_mode_r[1:0] == 2'h2 |=> period_zc == $past(zc_c)) else $error("phase C period");
   a_peak_en: assert property (@(posedge clk) disable iff (!rstn)
      peak_phase_en == measurement_mode_r[4:2]) else $error("peak enables wrong");
   a_pk_count3: assert property (@(posedge clk) disable iff (!rstn)
      peak_busy && zc_a && zc_b && zc_c && measurement_mode_r[4:2] == 3'h7
      && pk_cnt_r + 10'h003 < pk_target_r |=> pk_cnt_r == $past(pk_cnt_r) + 10'h003
      ) else $error("peak window count step");
   a_acc_abs: assert property (@(posedge clk) disable iff (!rstn)
      active_power_vld && accumulation_mode_r[1:0] == 2'h3 |=> !accum_power[MMC_PWR_W]
      && accum_power_vld) else $error("absolute accumulation sign");
   a_acc_signed: assert property (@(posedge clk) disable iff (!rstn)
      active_power_vld && accumulation_mode_r[1:0] != 2'h3
      |=> accum_power == {$past(active_power[23]), $past(active_power)}
      ) else $error("signed accumulation value");
   a_pk_done_pulse: assert property (@(posedge clk) disable iff (!rstn)
      peak_window_done |=> !peak_window_done) else $error("done not a pulse");

   c_abs_mode: cover property (@(posedge clk) disable iff (!rstn)
      active_power_vld && accumulation_mode_r[1:0] == 2'h3 && active_power[23]);
   c_peak_all: cover property (@(posedge clk) disable iff (!rstn)
      peak_window_done && measurement_mode_r[4:2] == 3'h7);
   c_per_rsv: cover property (@(posedge clk) disable iff (!rstn)
      measurement_mode_r[1:0] == 2'h3 && zc_a);
   c_wr_rd: cover property (@(posedge clk) disable iff (!rstn)
      reg_wr ##1 reg_rd);
   c_pk_start: cover property (@(posedge clk) disable iff (!rstn)
      peak_start && !peak_busy && peak_window_cycles != 8'h00);

endmodule // mmc_mode_regs
`default_nettype wire

// file: mmc_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
   import mmc_pkg::*;
;
   logic clk, rstn, reg_wr, reg_rd, peak_start, active_power_vld;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, general_configuration;
   logic [2:0] zc, peak_phase_en;
   logic [7:0] peak_window_cycles;
   logic [1:0] period_phase;
   logic period_zc, peak_window_done, peak_busy, accum_power_vld;
   logic [MMC_PWR_W-1:0] active_power;
   logic [MMC_PWR_W:0] accum_power, ea;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   typedef struct {logic [7:0] mm; logic [7:0] acc; logic [23:0] pw; logic [1:0] ep;
      logic [2:0] epk;} mmc_row_t;
   mmc_row_t rows[5] = '{'{8'h00, 8'h00, 24'hff_fffb, 2'h0, 3'h0},
      '{8'h1d, 8'h41, 24'hff_fff9, 2'h1, 3'h7}, '{8'h0a, 8'h02, 24'h00_0064, 2'h2, 3'h2},
      '{8'hf7, 8'hff, 24'hff_fff7, 2'h0, 3'h5}, '{8'h13, 8'h03, 24'h80_0000, 2'h0, 3'h4}};

   mmc_mode_regs i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zc_a(zc[0]), .zc_b(zc[1]),
      .zc_c(zc[2]), .peak_window_cycles(peak_window_cycles), .peak_start(peak_start),
      .period_zc(period_zc), .period_phase(period_phase), .peak_phase_en(peak_phase_en),
      .peak_window_done(peak_window_done), .peak_busy(peak_busy),
      .active_power(active_power), .active_power_vld(active_power_vld),
      .accum_power(accum_power), .accum_power_vld(accum_power_vld),
      .general_configuration(general_configuration));

   task automatic conclude();
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk("rdata", reg_rdata, e);
   endtask

   // Start a window of two crossings, pulse z once, then drain
   task automatic pk(input logic [7:0] mm, input logic [2:0] z, input logic e);
      logic seen;
      seen = 0;
      wr(MMC_MEASUREMENT_MODE_OFS, {8'h00, mm});
      peak_start <= 1'h1;
      @(posedge clk);
      peak_start <= 1'h0;
      zc <= z;
      #1 chk("busy", peak_busy, 1'h1);
      repeat (4) begin
         @(posedge clk);
         zc <= 3'h0;
         #1 seen |= peak_window_done;
      end
      chk("pk_done", seen, e);
      chk("busy", peak_busy, !e);
      repeat (4) begin
         @(posedge clk);
         zc <= 3'h7;
         @(posedge clk);
         zc <= 3'h0;
      end
      $display("test peak %h done", mm);
   endtask

   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      rstn = 0; reg_wr = 0; reg_rd = 0; peak_start = 0; active_power_vld = 0;
      reg_addr = 0; reg_wdata = 0; zc = 0; peak_window_cycles = 8'h02; active_power = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      #1 chk("peak_en", peak_phase_en, 3'h7);
      chk("per_ph", period_phase, 2'h0);
      rd(MMC_MEASUREMENT_MODE_OFS, 16'h001c);
      rd(MMC_ACCUMULATION_MODE_OFS, 16'h0000);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(MMC_MEASUREMENT_MODE_OFS, {8'h00, rows[i].mm});
         wr(MMC_ACCUMULATION_MODE_OFS, {8'h00, rows[i].acc});
         @(posedge clk);
         zc <= 3'h1 << rows[i].ep;
         active_power <= rows[i].pw;
         active_power_vld <= 1'h1;
         @(posedge clk);
         zc <= 3'h0;
         active_power_vld <= 1'h0;
         #1 ea = {rows[i].pw[23], rows[i].pw};
         if (rows[i].acc[1:0] == 2'h3 && ea[24]) ea = -ea;
         chk("per_zc", period_zc, 1'h1);
         chk("per_ph", period_phase, rows[i].ep);
         chk("peak_en", peak_phase_en, rows[i].epk);
         chk("acc_vld", accum_power_vld, 1'h1);
         chk("acc_pw", accum_power, ea);
         rd(MMC_MEASUREMENT_MODE_OFS, {11'h000, rows[i].mm[4:0]});
         rd(MMC_ACCUMULATION_MODE_OFS, {8'h00, rows[i].acc});
      end
      $display("test rows done");
      wr(MMC_GENCFG_OFS, 16'ha53c);
      #1 chk("gencfg", general_configuration, 16'ha53c);
      rd(MMC_GENCFG_OFS, 16'ha53c);
      rd(16'h1234, 16'h0000);
      $display("test bus done");
      pk(8'h1c, 3'h7, 1'h1);
      pk(8'h04, 3'h7, 1'h0);
      pk(8'h0c, 3'h3, 1'h1);
      pk(8'h10, 3'h3, 1'h0);
      peak_window_cycles <= 8'h07;
      wr(MMC_MEASUREMENT_MODE_OFS, 16'h001c);
      peak_start <= 1'h1;
      @(posedge clk);
      peak_start <= 1'h0;
      zc <= 3'h7;
      @(posedge clk);
      zc <= 3'h0;
      rd(MMC_PKSTAT_OFS, 16'h8003);
      @(posedge clk);
      zc <= 3'h7;
      @(posedge clk);
      zc <= 3'h1;
      @(posedge clk);
      zc <= 3'h0;
      #1 chk("pk_done", peak_window_done, 1'h1);
      chk("busy", peak_busy, 1'h0);
      rd(MMC_PKSTAT_OFS, 16'h0000);
      $display("test long window done");
      wr(MMC_MEASUREMENT_MODE_OFS, 16'h0002);
      wr(MMC_ACCUMULATION_MODE_OFS, 16'h0003);
      @(posedge clk);
      rstn <= 1'h0;
      @(posedge clk);
      #1 chk("peak_en", peak_phase_en, 3'h7);
      chk("per_ph", period_phase, 2'h0);
      chk("gencfg", general_configuration, 16'h0000);
      chk("acc_pw", accum_power, 25'h000_0000);
      @(posedge clk);
      rstn <= 1'h1;
      rd(MMC_MEASUREMENT_MODE_OFS, 16'h001c);
      rd(MMC_ACCUMULATION_MODE_OFS, 16'h0000);
      $display("test mid reset done");
      conclude();
   end
endmodule // testbench
`default_nettype wire
